// >>> rtl/sbe_break_echo.sv
// Operation
// - Spacing longer than a character is a break.
// - Spacing starts timer; no ready while spacing.
// - Break when timer idle, spacing, ready clear.
// - Break rise clears buffer, pulses busy, interrupts.
// - Break holds while line keeps spacing.
// - Write mode: data write clears ready instead.
// - Write idle: start sets timing, end clears.
// - Write mode busy follows timing; end interrupts.
// - Break during transmit flagged after character ends.
// - Unblock echoes received line onto transmit line.
// - Block suppresses the echo path.
// - Write mode transmit ignores block setting.
// - Ring rising edge interrupts only in read.
// - Nine-bit option drops one data stage.
// - Examine set when break or error set.
// - Interrupts raised through the attention flop.
// - Receiver frames one start, eight data (seven with nine-bit), stop.
`include "sbe_params.svh"
`timescale 1ns/100ps
module sbe_break_echo
  import sbe_pkg::*;
#(
  parameter logic [19:0] BIT_CYC_LO = 20'(`SBE_BIT_CYC_LO)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic        lineSpacingLevel,
  input  wire logic        ringLead,
  output wire logic        txSpacing,
  output wire logic        irq
);

  sbe_state_t  s;
  sbe_state_t  n;
  sbe_tmr_if   tmr ();
  sbe_reg_t    wrIdx;
  sbe_reg_t    rdIdx;
  logic [31:0] rdVal;
  logic [3:0]  irqSet;
  logic [3:0]  irqClr;
  logic        startGate;
  logic        brkCond;
  logic [3:0]  nData;

  function automatic sbe_reg_t decode(input logic [7:0] addr);
    sbe_reg_t r;
    r = REG_NONE;
    unique case (addr)
      `SBE_OFS_CTRL:     r = REG_CTRL;
      `SBE_OFS_STATUS:   r = REG_STAT;
      `SBE_OFS_RXDATA:   r = REG_RXD;
      `SBE_OFS_TXDATA:   r = REG_TXD;
      `SBE_OFS_IRQ_STAT: r = REG_IST;
      `SBE_OFS_IRQ_MASK: r = REG_IMSK;
      default:           r = REG_NONE;
    endcase
    return r;
  endfunction

  sbe_char_timer u_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tp      (tmr.tmr)
  );

  assign nData = s.nineBit ? `SBE_DATA_BITS_NINE : `SBE_DATA_BITS_STD;
  assign tmr.start = s.tmrStart;
  assign tmr.halfFirst = !s.txActive;
  assign tmr.bitCyc = s.highSpeed ? (BIT_CYC_LO >> `SBE_SPEED_SHIFT) : BIT_CYC_LO;
  assign tmr.nBits = nData + `SBE_FRAME_EXTRA;

  assign wrIdx = decode(s.awAddr);
  assign rdIdx = decode(araddr);

  always_comb begin
    rdVal = 32'h0;
    unique case (rdIdx)
      REG_CTRL: begin
        rdVal[`SBE_CTRL_WRITE] = s.writeMode;
        rdVal[`SBE_CTRL_UNBLOCK] = s.unblock;
        rdVal[`SBE_CTRL_HISPEED] = s.highSpeed;
        rdVal[`SBE_CTRL_NINEBIT] = s.nineBit;
        rdVal[`SBE_CTRL_RINGEN] = s.ringEn;
      end
      REG_STAT: begin
        rdVal[`SBE_ST_ERR] = s.errFlag;
        rdVal[`SBE_ST_BREAK] = s.lineBreakFlag;
        rdVal[`SBE_ST_RING] = s.ringDly;
        rdVal[`SBE_ST_BUSY] = s.interfaceBusyBit;
        rdVal[`SBE_ST_EXAMINE] = s.lineBreakFlag | s.errFlag;
        rdVal[`SBE_ST_READY] = s.readyFlag;
        rdVal[`SBE_ST_TIMING] = s.timingFlop;
      end
      REG_RXD:  rdVal[7:0] = s.byteBuf;
      REG_IST:  rdVal[3:0] = s.irqStat;
      REG_IMSK: rdVal[3:0] = s.irqMask;
      default:  rdVal = 32'h0;
    endcase
  end

  // Timer starts from a queued transmit byte in write mode or a fresh spacing edge.
  assign startGate = !s.timingFlop && !s.tmrStart
                     && ((s.writeMode && s.txPending) || (s.delayedLineData && s.lineArmed));
  assign brkCond = !s.timingFlop && !s.tmrStart && s.delayedLineData && !s.readyFlag;

  always_comb begin
    n = s;
    irqSet = 4'h0;
    irqClr = 4'h0;
    n.tmrStart = 1'b0;

    // Bus slave: address and data may arrive in either order.
    if (awvalid && s.awready) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (bready && s.bvalid) begin
      n.bvalid = 1'b0;
    end
    if (rready && s.rvalid) begin
      n.rvalid = 1'b0;
    end

    // Serial front end and character timing.
    n.delayedLineData = lineSpacingLevel;
    if (!s.delayedLineData) begin
      n.lineArmed = 1'b1;
    end else if (s.timingFlop) begin
      n.lineArmed = 1'b0;
    end
    if (startGate) begin
      n.timingFlop = 1'b1;
      n.tmrStart = 1'b1;
      n.bitIdx = 4'h0;
      if (s.writeMode && s.txPending) begin
        n.txActive = 1'b1;
        n.txPending = 1'b0;
        n.txShift = s.nineBit ? {2'b11, s.txHold[6:0], 1'b0} : {1'b1, s.txHold, 1'b0};
      end else begin
        n.txActive = 1'b0;
        n.lineArmed = 1'b0;
        if (!s.writeMode) begin
          n.readyFlag = 1'b0;
        end
      end
    end
    if (tmr.tick) begin
      if (s.txActive) begin
        n.txShift = {1'b1, s.txShift[9:1]};
      end else begin
        n.bitIdx = s.bitIdx + 4'h1;
        if (s.bitIdx != 4'h0 && s.bitIdx <= nData) begin
          n.rxShift = {!s.delayedLineData, s.rxShift[7:1]};
        end
      end
    end
    if (tmr.done) begin
      n.timingFlop = 1'b0;
      n.txActive = 1'b0;
      n.readyFlag = !s.delayedLineData;
      if (s.writeMode) begin
        irqSet[`SBE_IRQ_TXDONE] = 1'b1;
      end else if (!s.txActive && !s.delayedLineData) begin
        n.byteBuf = s.nineBit ? {1'b0, s.rxShift[7:1]} : s.rxShift;
        if (s.byteAvail) begin
          n.errFlag = 1'b1;
        end
        n.byteAvail = 1'b1;
        irqSet[`SBE_IRQ_RX] = 1'b1;
      end
    end

    // Register write, performed once both halves are held.
    if (s.awHave && s.wHave && !s.bvalid) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wrIdx == REG_NONE) ? `SBE_RESP_SLVERR : `SBE_RESP_OKAY;
      if (s.wStrb[0]) begin
        unique case (wrIdx)
          REG_CTRL: begin
            n.writeMode = s.wData[`SBE_CTRL_WRITE];
            n.unblock = s.wData[`SBE_CTRL_UNBLOCK];
            n.highSpeed = s.wData[`SBE_CTRL_HISPEED];
            n.nineBit = s.wData[`SBE_CTRL_NINEBIT];
            n.ringEn = s.wData[`SBE_CTRL_RINGEN];
          end
          REG_TXD: begin
            if (s.writeMode && !s.txPending && !s.txActive) begin
              n.txHold = s.wData[7:0];
              n.txPending = 1'b1;
              n.readyFlag = 1'b0;
            end
          end
          REG_IMSK: n.irqMask = s.wData[3:0];
          default: n.irqMask = s.irqMask;
        endcase
      end
    end

    // Register read; data and interrupt status reads have side effects.
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rdVal;
      n.rresp = (rdIdx == REG_NONE) ? `SBE_RESP_SLVERR : `SBE_RESP_OKAY;
      if (rdIdx == REG_RXD) begin
        n.byteAvail = 1'b0;
        n.errFlag = 1'b0;
      end
      if (rdIdx == REG_IST) begin
        irqClr = s.irqStat;
      end
    end
    if (tmr.done && !s.writeMode && !s.txActive && !s.delayedLineData) begin
      n.byteAvail = 1'b1;
      if (s.byteAvail) begin
        n.errFlag = 1'b1;
      end
    end

    // Break indication follows the condition; its rising edge flushes the buffer.
    n.lineBreakFlag = brkCond;
    if (brkCond && !s.lineBreakFlag) begin
      n.byteBuf = 8'h00;
      n.byteAvail = 1'b0;
      irqSet[`SBE_IRQ_BREAK] = 1'b1;
    end

    // Busy tracks timing in write mode and data availability in read mode.
    if (s.writeMode) begin
      n.interfaceBusyBit = n.timingFlop || n.txPending;
    end else if (brkCond && !s.lineBreakFlag) begin
      n.interfaceBusyBit = 1'b0;
    end else begin
      n.interfaceBusyBit = !n.byteAvail;
    end

    n.ringDly = ringLead;
    if (ringLead && !s.ringDly && s.ringEn && !s.writeMode) begin
      irqSet[`SBE_IRQ_RING] = 1'b1;
    end

    // Transmit line: own shifter in write mode, echo of the receiver otherwise.
    if (s.writeMode) begin
      n.txSpacing = s.txActive && !s.txShift[0];
    end else begin
      n.txSpacing = s.unblock && s.delayedLineData;
    end

    n.irqStat = (s.irqStat & ~irqClr) | irqSet;
    n.attentionFlop = |(n.irqStat & n.irqMask);
    n.awready = !n.awHave && !n.bvalid;
    n.wready = !n.wHave && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.readyFlag <= `SBE_RST_READY;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign txSpacing = s.txSpacing;
  assign irq = s.attentionFlop;

endmodule

// >>> rtl/sbe_params.svh
`ifndef SBE_PARAMS_SVH
`define SBE_PARAMS_SVH

`define SBE_CLK_PERIOD_NS   40
`define SBE_BIT_TIME_LO_NS  3330000
`define SBE_BIT_CYC_LO      ((`SBE_BIT_TIME_LO_NS) / (`SBE_CLK_PERIOD_NS))
`define SBE_SPEED_SHIFT     2
`define SBE_DATA_BITS_STD   4'h8
`define SBE_DATA_BITS_NINE  4'h7
`define SBE_FRAME_EXTRA     4'h2

`define SBE_OFS_CTRL        8'h00
`define SBE_OFS_STATUS      8'h04
`define SBE_OFS_RXDATA      8'h08
`define SBE_OFS_TXDATA      8'h0c
`define SBE_OFS_IRQ_STAT    8'h10
`define SBE_OFS_IRQ_MASK    8'h14

`define SBE_CTRL_WRITE      0
`define SBE_CTRL_UNBLOCK    1
`define SBE_CTRL_HISPEED    2
`define SBE_CTRL_NINEBIT    3
`define SBE_CTRL_RINGEN     4

`define SBE_ST_ERR          0
`define SBE_ST_BREAK        2
`define SBE_ST_RING         3
`define SBE_ST_BUSY         4
`define SBE_ST_EXAMINE      5
`define SBE_ST_READY        8
`define SBE_ST_TIMING       9

`define SBE_IRQ_RX          0
`define SBE_IRQ_BREAK       1
`define SBE_IRQ_TXDONE      2
`define SBE_IRQ_RING        3

`define SBE_RST_READY       1'b1
`define SBE_RESP_OKAY       2'h0
`define SBE_RESP_SLVERR     2'h2

`endif

// >>> rtl/sbe_pkg.sv
package sbe_pkg;

  typedef enum logic [2:0] {
    REG_CTRL  = 3'h0,
    REG_STAT  = 3'h1,
    REG_RXD   = 3'h2,
    REG_TXD   = 3'h3,
    REG_IST   = 3'h4,
    REG_IMSK  = 3'h5,
    REG_NONE  = 3'h7
  } sbe_reg_t;

  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_RUN  = 1'b1
  } sbe_tmr_state_t;

  typedef struct packed {
    sbe_tmr_state_t st;
    logic [19:0]    cnt;
    logic [3:0]     left;
    logic           tick;
    logic           done;
  } sbe_tmr_t;

  typedef struct packed {
    logic        awHave;
    logic [7:0]  awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        writeMode;
    logic        unblock;
    logic        highSpeed;
    logic        nineBit;
    logic        ringEn;
    logic        delayedLineData;
    logic        lineArmed;
    logic        timingFlop;
    logic        tmrStart;
    logic        txActive;
    logic        txPending;
    logic [7:0]  txHold;
    logic [9:0]  txShift;
    logic        readyFlag;
    logic        lineBreakFlag;
    logic [7:0]  byteBuf;
    logic        byteAvail;
    logic        errFlag;
    logic [7:0]  rxShift;
    logic [3:0]  bitIdx;
    logic        ringDly;
    logic        interfaceBusyBit;
    logic [3:0]  irqStat;
    logic [3:0]  irqMask;
    logic        attentionFlop;
    logic        txSpacing;
  } sbe_state_t;

endpackage

// >>> rtl/sbe_tmr_if.sv
`timescale 1ns/100ps
interface sbe_tmr_if;
  logic        start;
  logic        halfFirst;
  logic [19:0] bitCyc;
  logic [3:0]  nBits;
  logic        tick;
  logic        done;

  modport ctl (output start, output halfFirst, output bitCyc, output nBits, input tick, input done);
  modport tmr (input start, input halfFirst, input bitCyc, input nBits, output tick, output done);
endinterface

// >>> rtl/sbe_char_timer.sv
`timescale 1ns/100ps
module sbe_char_timer
  import sbe_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  sbe_tmr_if.tmr    tp
);

  sbe_tmr_t s;
  sbe_tmr_t n;

  // Counts bit periods; the first may be half a bit so ticks fall mid-bit.
  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.done = 1'b0;
    unique case (s.st)
      TMR_IDLE: begin
        if (tp.start) begin
          n.st = TMR_RUN;
          n.cnt = tp.halfFirst ? {1'b0, tp.bitCyc[19:1]} : tp.bitCyc;
          n.left = tp.nBits;
        end
      end
      TMR_RUN: begin
        if (s.cnt <= 20'h1) begin
          n.tick = 1'b1;
          n.cnt = tp.bitCyc;
          n.left = s.left - 4'h1;
          if (s.left == 4'h1) begin
            n.done = 1'b1;
            n.st = TMR_IDLE;
          end
        end else begin
          n.cnt = s.cnt - 20'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tp.tick = s.tick;
  assign tp.done = s.done;

endmodule

// >>> verif/sbe_break_echo_asserts.sv
`timescale 1ns/100ps
module sbe_break_echo_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        lineSpacingLevel,
  input wire logic        ringLead,
  input wire logic        txSpacing,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [4:0] ctrlQ;
  logic [2:0] setQ;
  logic       wrCtrl;
  // Control writes are tracked so the echo checks only run once a mode has settled.
  assign wrCtrl = awvalid && awready && wvalid && wready && awaddr == 8'h00 && wstrb[0];
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrlQ <= 5'h00;
      setQ  <= 3'h0;
    end else begin
      ctrlQ <= wrCtrl ? wdata[4:0] : ctrlQ;
      setQ  <= wrCtrl ? 3'h0 : (setQ == 3'h7 ? setQ : setQ + 3'h1);
    end
  end
  echo_path_a: assert property (setQ == 3'h7 && ctrlQ[1:0] == 2'b10 |-> txSpacing == $past(lineSpacingLevel, 2))
    else $error("echo path mismatch");
  block_quiet_a: assert property (setQ == 3'h7 && ctrlQ[1:0] == 2'b00 |-> !txSpacing)
    else $error("transmit line active while blocked");
  write_resp_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response late");
  read_resp_a: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped");
  unmapped_read_a: assert property (arvalid && arready && araddr > 8'h14 |=> rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
  ctrl_readback_a: assert property (arvalid && arready && araddr == 8'h00 |=> rdata == {27'h0, ctrlQ})
    else $error("control readback mismatch");
  cover property (setQ == 3'h7 && ctrlQ[1:0] == 2'b10 && txSpacing);
  cover property (rvalid && rresp == 2'h2);
  cover property ($rose(irq));
endmodule

bind sbe_break_echo sbe_break_echo_asserts chk (.clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .lineSpacingLevel(lineSpacingLevel),
  .ringLead(ringLead), .txSpacing(txSpacing), .irq(irq));

// >>> verif/sbe_terminal_model.sv
`timescale 1ns/100ps
module sbe_terminal_model #(
  parameter int BIT = 40
) (
  input  wire logic clk_sys,
  output logic      lineSpacingLevel,
  output logic      ringLead
);
  int bitLen;
  // The line idles marking, which is the low level here.
  initial begin
    lineSpacingLevel = 1'b0;
    ringLead = 1'b0;
    bitLen = BIT;
  end
  task automatic hold(input logic v, input int n);
    lineSpacingLevel <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  // A frame is one start bit, n data bits sent low bit first, and a stop bit.
  task automatic send(input logic [7:0] b, input int n);
    hold(1'b1, bitLen);
    for (int i = 0; i < n; i++) hold(~b[i], bitLen);
    hold(1'b0, bitLen + 4);
  endtask
  task automatic ring(input logic v);
    ringLead <= v;
  endtask
endmodule

// >>> verif/test_serial_break_echo.sv
`timescale 1ns/100ps
module test_serial_break_echo;
  localparam int          B   = 40;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic        clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready, line, ringW;
  logic        awready, wready, bvalid, arready, rvalid, txSpacing, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [9:0]  fr;
  int          nErrors, testsRun;

  sbe_break_echo #(.BIT_CYC_LO(20'd40)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .lineSpacingLevel(line),
    .ringLead(ringW), .txSpacing(txSpacing), .irq(irq));
  sbe_terminal_model #(.BIT(B)) term (.clk_sys(clk_sys), .lineSpacingLevel(line), .ringLead(ringW));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdt(a);
    chk(rd & m, e);
  endtask
  // Samples the transmit line in the middle of each of the ten bit cells.
  task automatic cap();
    for (int i = 0; i < 200 && txSpacing !== 1'b1; i++) @(posedge clk_sys);
    repeat (B / 2) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      fr[i] = txSpacing;
      repeat (B) @(posedge clk_sys);
    end
  endtask
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    nErrors = 0;
    testsRun = 0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rc(8'h00, ALL, 32'h0);
    rc(8'h14, ALL, 32'h0);
    rc(8'h04, 32'h100, 32'h100);
    wr(8'h18, 32'h1);
    chk(32'(rs), 32'h2);
    rc(8'h18, ALL, 32'h0);
    chk(32'(rs), 32'h2);
    $display("test reset done");
    wr(8'h14, 32'hf);
    wr(8'h00, 32'h2);
    term.send(8'ha5, 8);
    chk(32'(irq), 32'h1);
    rc(8'h10, ALL, 32'h1);
    rc(8'h08, ALL, 32'ha5);
    wr(8'h00, 32'h8);
    term.send(8'h35, 7);
    rc(8'h08, ALL, 32'h35);
    rc(8'h10, ALL, 32'h1);
    wr(8'h00, 32'h4);
    term.bitLen = B / 4;
    term.send(8'h69, 8);
    term.send(8'h96, 8);
    rc(8'h04, 32'h21, 32'h21);
    rc(8'h08, ALL, 32'h96);
    rc(8'h04, 32'h21, 32'h0);
    term.bitLen = B;
    $display("test receive done");
    wr(8'h00, 32'h0);
    term.send(8'h3c, 8);
    term.hold(1'b1, 12 * B);
    rc(8'h04, 32'h24, 32'h24);
    chk(32'(irq), 32'h1);
    rc(8'h10, ALL, 32'h3);
    rc(8'h08, ALL, 32'h0);
    rc(8'h04, 32'h4, 32'h4);
    term.hold(1'b0, 8);
    rc(8'h04, 32'h4, 32'h0);
    rc(8'h10, ALL, 32'h0);
    $display("test break done");
    wr(8'h00, 32'h10);
    term.ring(1'b1);
    repeat (4) @(posedge clk_sys);
    rc(8'h10, ALL, 32'h8);
    term.ring(1'b0);
    wr(8'h00, 32'h11);
    term.ring(1'b1);
    repeat (4) @(posedge clk_sys);
    rc(8'h10, 32'h8, 32'h0);
    term.ring(1'b0);
    $display("test ring done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, {30'h0, k[0], 1'b1});
      wr(8'h0c, 32'h5a);
      chk(32'(rs), 32'h0);
      rc(8'h04, 32'h10, 32'h10);
      fork
        cap();
        term.hold(k[0], 14 * B);
      join
      chk(32'(fr), {22'h0, 1'b0, ~8'h5a, 1'b1});
      rc(8'h04, 32'h14, {29'h0, k[0], 2'b00});
      rc(8'h10, 32'h4, 32'h4);
      term.hold(1'b0, 8);
    end
    $display("test transmit done");
    finalReport();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    nErrors++;
    $display("ERROR %0t: watchdog timeout", $time);
    finalReport();
  end
endmodule
